// ### lcd_scan.sv
// Purpose: Display memory addressing, host access and display scan
// Assumes: Host command port on sys_clk; display clock pin asynchronous
// Notes: Host entries pass through a 16-word FIFO
`timescale 1ns/1ns
`default_nettype none
`include "lcd_scan_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module sync_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic ready_r;
  logic push;
  logic pop;
  assign in_ready = ready_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // sync_fifo

////////////////////////////////////////////////////////////////////////////////
module lcd_scan #(
  parameter logic [11:0] OSC_DIV = `OSC_DIV,
  parameter logic [11:0] CLK_HIGH_CYC = `CLK_HIGH_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host entries
  input wire logic wr_valid,
  input wire lcd_scan_pkg::host_entry_t wr_entry,
  output logic wr_ready,
  // Host read data
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  // Display clock pin
  input wire logic display_clock_pin,
  // Driver outputs
  output lcd_scan_pkg::drive_level_t [`COLS-1:0] segment_outputs,
  output lcd_scan_pkg::drive_level_t [`LINES-1:0] common_outputs,
  output lcd_scan_pkg::drive_level_t indicator_common_output,
  output logic frame_alternation_signal,
  // Power enables
  output lcd_scan_pkg::power_ctl_t power
);
  import lcd_scan_pkg::*;

  logic [7:0] display_pixel_memory [`PAGES*`COLS];
  host_entry_t q_entry;
  logic q_valid;
  logic pop_ready;
  logic take;
  logic is_cmd;
  logic is_acc;
  logic [7:0] col_r;
  logic [3:0] page_r;
  logic addr_ok;
  logic [10:0] host_idx;
  logic [7:0] holder_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic [5:0] start_line_r;
  logic seg_rev_r;
  logic com_rev_r;
  logic disp_on_r;
  logic inverse_r;
  logic all_on_r;
  power_ctl_t power_r;
  ////////////////////////////////////////////////////////////////////////////
  // Host entry FIFO; drain stalls while read data waits
  assign pop_ready = !(rd_valid_r && !rd_ready);
  assign take = q_valid && pop_ready;
  assign is_cmd = take && !q_entry.data_command_select; // RULE18
  assign is_acc = take && q_entry.data_command_select;
  sync_fifo #(.WIDTH($bits(host_entry_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(wr_valid),
    .in_data(wr_entry),
    .in_ready(wr_ready),
    .out_valid(q_valid),
    .out_data(q_entry),
    .out_ready(pop_ready)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Page and column counters
  assign addr_ok = (page_r <= `LAST_PAGE); // RULE20
  assign host_idx = 11'(page_r) * 11'(`COLS) + 11'(col_r); // RULE1
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      col_r <= 8'h00;
      page_r <= 4'h0;
    end else if (is_cmd) begin
      if (q_entry.value[7:4] == `CMD_PAGE) begin
        page_r <= q_entry.value[3:0]; // RULE3
      end else if (q_entry.value[7:4] == `CMD_COL_HI) begin
        col_r <= {q_entry.value[3:0], col_r[3:0]}; // RULE4
      end else if (q_entry.value[7:4] == `CMD_COL_LO) begin
        col_r <= {col_r[7:4], q_entry.value[3:0]}; // RULE4
      end
    end else if (is_acc) begin
      if (col_r == `LAST_COL) begin
        col_r <= 8'h00; // RULE5
        page_r <= (page_r == `LAST_PAGE) ? 4'h0 : page_r + 4'h1; // RULE6
      end else begin
        col_r <= col_r + 8'h01; // RULE4
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Display settings and power enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_line_r <= 6'h00;
      seg_rev_r <= 1'b0;
      com_rev_r <= 1'b0;
      disp_on_r <= 1'b0;
      inverse_r <= 1'b0;
      all_on_r <= 1'b0;
      power_r <= '0;
    end else if (is_cmd) begin
      if (q_entry.value[7:6] == `CMD_LINE) begin
        start_line_r <= q_entry.value[5:0]; // RULE9
      end
      if (q_entry.value[7:3] == `CMD_PWR) begin
        power_r <= q_entry.value[2:0]; // RULE17
      end
      case (q_entry.value)
        `CMD_SEG_NORM: seg_rev_r <= 1'b0; // RULE8
        `CMD_SEG_REV: seg_rev_r <= 1'b1; // RULE8
        `CMD_COM_NORM: com_rev_r <= 1'b0; // RULE10
        `CMD_COM_REV: com_rev_r <= 1'b1; // RULE10
        `CMD_DISP_OFF: disp_on_r <= 1'b0;
        `CMD_DISP_ON: disp_on_r <= 1'b1;
        `CMD_INV_OFF: inverse_r <= 1'b0;
        `CMD_INV_ON: inverse_r <= 1'b1;
        `CMD_ALL_OFF: all_on_r <= 1'b0;
        `CMD_ALL_ON: all_on_r <= 1'b1;
        default: ;
      endcase
    end
  end
  assign power = power_r;
  ////////////////////////////////////////////////////////////////////////////
  // Memory write; only data writes touch memory
  always_ff @(posedge sys_clk) begin
    if (is_acc && !q_entry.read && addr_ok) begin
      display_pixel_memory[host_idx] <= (page_r == `LAST_PAGE) ?
        {7'h00, q_entry.value[0]} : q_entry.value; // RULE2 RULE3 RULE12
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus holder read: answer is the previously held byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holder_r <= 8'h00;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else if (is_acc && q_entry.read) begin
      rd_data_r <= holder_r; // RULE19
      holder_r <= addr_ok ? display_pixel_memory[host_idx] : 8'h00;
      rd_valid_r <= 1'b1;
    end else if (rd_ready) begin
      rd_valid_r <= 1'b0;
    end
  end
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  ////////////////////////////////////////////////////////////////////////////
  // Display clock source
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic [11:0] high_cnt_r;
  logic [11:0] osc_cnt_r;
  logic int_mode;
  logic disp_tick;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
    end else begin
      pin_s1_r <= display_clock_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      high_cnt_r <= 12'h000;
      osc_cnt_r <= 12'h000;
    end else begin
      if (!pin_s2_r) begin
        high_cnt_r <= 12'h000;
      end else if (high_cnt_r != CLK_HIGH_CYC) begin
        high_cnt_r <= high_cnt_r + 12'h001;
      end
      osc_cnt_r <= (osc_cnt_r == OSC_DIV - 12'h001) ? 12'h000 : osc_cnt_r + 12'h001;
    end
  end
  assign int_mode = (high_cnt_r == CLK_HIGH_CYC); // RULE13
  assign disp_tick = int_mode ? (osc_cnt_r == 12'h000) : (pin_s2_r && !pin_s3_r); // RULE13
  ////////////////////////////////////////////////////////////////////////////
  // Line scan and fetch, on a port separate from host access
  scan_state_t scan_state_r;
  logic [6:0] scan_idx_r;
  logic [6:0] shown_idx_r;
  logic [5:0] frame_start_r;
  logic [7:0] fetch_col_r;
  logic [`COLS-1:0] line_buf_r;
  logic fr_r;
  logic [5:0] fetch_line;
  logic [3:0] fetch_page;
  logic [2:0] fetch_bit;
  logic [10:0] fetch_idx;
  assign fetch_line = frame_start_r + scan_idx_r[5:0]; // RULE9
  assign fetch_page = (scan_idx_r == `IND_IDX) ? `LAST_PAGE : {1'b0, fetch_line[5:3]};
  assign fetch_bit = (scan_idx_r == `IND_IDX) ? 3'h0 : fetch_line[2:0]; // RULE2
  assign fetch_idx = 11'(fetch_page) * 11'(`COLS) + 11'(fetch_col_r);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_state_r <= SCAN_IDLE;
      scan_idx_r <= 7'h00;
      shown_idx_r <= 7'h00;
      frame_start_r <= 6'h00;
      fetch_col_r <= 8'h00;
      fr_r <= 1'b0;
    end else if (disp_tick) begin
      shown_idx_r <= scan_idx_r;
      scan_state_r <= SCAN_FETCH;
      fetch_col_r <= 8'h00;
      if (scan_idx_r == `IND_IDX) begin
        scan_idx_r <= 7'h00;
        frame_start_r <= start_line_r; // RULE11
        fr_r <= ~fr_r; // RULE15
      end else begin
        scan_idx_r <= scan_idx_r + 7'h01;
      end
    end else begin
      unique case (scan_state_r)
        SCAN_IDLE: ;
        SCAN_FETCH: begin
          if (fetch_col_r == `LAST_COL) begin
            scan_state_r <= SCAN_IDLE;
          end else begin
            fetch_col_r <= fetch_col_r + 8'h01;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (scan_state_r == SCAN_FETCH && !disp_tick) begin
      line_buf_r[fetch_col_r] <= display_pixel_memory[fetch_idx][fetch_bit]; // RULE7
    end
  end
  assign frame_alternation_signal = fr_r;
  ////////////////////////////////////////////////////////////////////////////
  // Output latch and four-level selection
  genvar gi;
  generate
    for (gi = 0; gi < `COLS; gi++) begin : g_seg
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          segment_outputs[gi] <= '0;
        end else if (disp_tick) begin
          segment_outputs[gi] <= {fr_r, disp_on_r && (all_on_r ||
            (inverse_r ^ line_buf_r[seg_rev_r ? `COLS-1-gi : gi]))}; // RULE8 RULE12 RULE14 RULE16
        end
      end
    end
    for (gi = 0; gi < `LINES; gi++) begin : g_com
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          common_outputs[gi] <= '0;
        end else if (disp_tick) begin
          common_outputs[gi] <= {fr_r,
            scan_idx_r == 7'(com_rev_r ? `LINES-1-gi : gi)}; // RULE10 RULE14 RULE16
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      indicator_common_output <= '0;
    end else if (disp_tick) begin
      indicator_common_output <= {fr_r, scan_idx_r == `IND_IDX}; // RULE16
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_acc_at_last;
    is_acc && col_r == `LAST_COL;
  endsequence
  a_col_advance: assert property (is_acc && col_r != `LAST_COL |=> col_r == $past(col_r) + 8'h01) // RULE4
    else $error("column did not advance");
  a_col_wrap: assert property (s_acc_at_last |=> col_r == 8'h00) // RULE5
    else $error("column did not wrap");
  a_page_advance: assert property (s_acc_at_last and page_r < `LAST_PAGE |=> page_r == $past(page_r) + 4'h1) // RULE5
    else $error("page did not advance");
  a_page_last_wrap: assert property (s_acc_at_last and page_r == `LAST_PAGE |=> page_r == 4'h0) // RULE6
    else $error("page did not return to zero");
  a_page_load: assert property (is_cmd && q_entry.value[7:4] == `CMD_PAGE |=> page_r == $past(q_entry.value[3:0])) // RULE3
    else $error("page not loaded");
  a_dummy_read: assert property (is_acc && q_entry.read |=> rd_valid && rd_data == $past(holder_r)) // RULE19
    else $error("read did not return held byte");
  a_fr_toggle: assert property (disp_tick && scan_idx_r == `IND_IDX |=> fr_r != $past(fr_r)) // RULE15
    else $error("frame signal did not toggle");
  a_fr_steady: assert property (disp_tick && scan_idx_r != `IND_IDX |=> $stable(fr_r)) // RULE15
    else $error("frame signal toggled mid frame");
  a_start_latch: assert property (disp_tick && scan_idx_r != `IND_IDX |=> $stable(frame_start_r)) // RULE11
    else $error("start line changed mid frame");
  a_power_set: assert property (is_cmd && q_entry.value[7:3] == `CMD_PWR |=> power == $past(q_entry.value[2:0])) // RULE17
    else $error("power enables not set");
  a_com_select: assert property (disp_tick && !com_rev_r && scan_idx_r == 7'h00 |=> common_outputs[0][0]) // RULE10
    else $error("first common not selected");
endmodule // lcd_scan
`default_nettype wire

// ### lcd_scan_regs.svh
// Purpose: Constants for the display memory addressing and scan logic
// Assumes: 20 MHz sys_clk
// Notes: Command byte encodings and scan sizes
//
// Summary of operation
// RULE1: Memory holds 65 rows by 132 columns: eight 8-row pages plus one row.
// RULE2: A data byte fills eight vertical pixels of one column, bit order along commons.
// RULE3: Page command loads page counter; page 8 is indicator row, only bit 0 used.
// RULE4: Column command loads column counter; each data access adds one.
// RULE5: Access at column 83H wraps column to 00H and advances page.
// RULE6: Access at column 83H of page 8 returns column and page to zero.
// RULE7: Host access runs independently of refresh reads, so no visible disturbance.
// RULE8: Segment direction maps column n to segment n or to segment 131 minus n.
// RULE9: Start line is shown on first common; later commons ascend, wrapping 3FH to 00H.
// RULE10: Common direction puts start line on common 0 or on common 63.
// RULE11: Start line changes take effect on later frames, allowing scrolling.
// RULE12: On/off, inverse and all-on alter only the output latch, never memory.
// RULE13: Internal oscillator when clock pin held high, else external clock; low when stopped.
// RULE14: Each line is latched and presented to segments on the display clock; commons scanned.
// RULE15: Frame alternation signal toggles once per frame, a two-frame pattern.
// RULE16: Each output picks one of four levels from pixel, scan state and frame signal.
// RULE17: Power command switches booster, regulator and follower enables independently.
// RULE18: Host drives data/command select high for data and low for commands.
// RULE19: First read after address set or write returns stale data; host does a dummy read.
// RULE20: Column counter is 8 bits, page counter 4 bits; pages above 8 unused.
`ifndef LCD_SCAN_REGS_SVH
`define LCD_SCAN_REGS_SVH
`define COLS 132
`define LINES 64
`define PAGES 9
`define LAST_COL 8'h83
`define LAST_PAGE 4'h8
`define IND_IDX 7'h40
`define CMD_PAGE 4'hB
`define CMD_COL_HI 4'h1
`define CMD_COL_LO 4'h0
`define CMD_LINE 2'h1
`define CMD_PWR 5'h05
`define CMD_SEG_NORM 8'hA0
`define CMD_SEG_REV 8'hA1
`define CMD_ALL_OFF 8'hA4
`define CMD_ALL_ON 8'hA5
`define CMD_INV_OFF 8'hA6
`define CMD_INV_ON 8'hA7
`define CMD_DISP_OFF 8'hAE
`define CMD_DISP_ON 8'hAF
`define CMD_COM_NORM 8'hC0
`define CMD_COM_REV 8'hC8
`define OSC_DIV 12'd2500
`define CLK_HIGH_CYC 12'd1000
`endif

// ### lcd_scan_pkg.sv
// Purpose: Types for the display memory addressing and scan logic
// Assumes: Nothing
// Notes: Host entries carry the data/command select with the byte
package lcd_scan_pkg;
  typedef struct packed {
    logic data_command_select;
    logic read;
    logic [7:0] value;
  } host_entry_t;
  typedef struct packed {
    logic booster;
    logic regulator;
    logic follower;
  } power_ctl_t;
  typedef logic [1:0] drive_level_t;
  typedef enum logic {
    SCAN_IDLE = 1'b0,
    SCAN_FETCH = 1'b1
  } scan_state_t;
endpackage

// ### lcd_host_model.sv
// Purpose: Host model that offers entries and takes read answers
// Assumes: Entries change just after a rising edge
// Notes: Stall holds rd_ready low so the FIFO backs up
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////
module lcd_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Entry side
  output logic wr_valid,
  output lcd_scan_pkg::host_entry_t wr_entry,
  input wire logic wr_ready,
  // Read answer side
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_ready,
  // Slow answer control
  input wire logic stall
);
  import lcd_scan_pkg::*;
  logic [7:0] got_q[$];
  initial begin
    wr_valid = 1'b0;
    wr_entry = '0;
  end
  assign rd_ready = !stall;
  // Answers taken at the edge that sees rd_ready
  always @(posedge sys_clk) begin
    if (!rst && rd_valid && rd_ready) begin
      got_q.push_back(rd_data);
    end
  end
  // Offer one entry, held until taken
  task automatic send(input logic dcs, input logic rd, input logic [7:0] v);
    wr_valid <= 1'b1;
    wr_entry <= {dcs, rd, v};
    @(negedge sys_clk);
    while (wr_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // Released bus shows the inverse of the last byte
  task automatic idle();
    wr_valid <= 1'b0;
    wr_entry <= {1'b0, 1'b0, ~wr_entry.value};
  endtask
endmodule // lcd_host_model
`default_nettype wire

// ### lcd_scan_tb.sv
// Purpose: Self-checking bench for display addressing and scan
// Assumes: Short oscillator divider and clock-pin hold
// Notes: Display memory is not cleared, so only written columns are judged
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////
module lcd_scan_tb;
  import lcd_scan_pkg::*;
  localparam int FRAME = 9750;
  localparam int CEIL = 95000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic display_clock_pin = 1'b1;
  logic stall = 1'b0;
  logic wr_valid;
  host_entry_t wr_entry;
  logic wr_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rd_ready;
  drive_level_t [131:0] segment_outputs;
  drive_level_t [63:0] common_outputs;
  drive_level_t indicator_common_output;
  logic frame_alternation_signal;
  power_ctl_t power;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  lcd_scan #(.OSC_DIV(12'h096), .CLK_HIGH_CYC(12'h008), .FIFO_DEPTH(16)) u_lcd_scan (
    .sys_clk(sys_clk), .rst(rst), .wr_valid(wr_valid), .wr_entry(wr_entry), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .display_clock_pin(display_clock_pin),
    .segment_outputs(segment_outputs), .common_outputs(common_outputs),
    .indicator_common_output(indicator_common_output),
    .frame_alternation_signal(frame_alternation_signal), .power(power));
  lcd_host_model u_lcd_host_model (
    .sys_clk(sys_clk), .rst(rst), .wr_valid(wr_valid), .wr_entry(wr_entry), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .stall(stall));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      err_total++;
      $display("ERROR timeout expected done seen running");
      print_verdict();
    end
  end
  task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_count(input string nm, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] v);
    u_lcd_host_model.send(1'b0, 1'b0, v);
  endtask
  task automatic wr(input logic [7:0] v);
    u_lcd_host_model.send(1'b1, 1'b0, v);
  endtask
  task automatic rd();
    u_lcd_host_model.send(1'b1, 1'b1, 8'h00);
  endtask
  task automatic at(input logic [3:0] p, input logic [7:0] c);
    u_lcd_host_model.got_q.delete();
    cmd({4'hB, p});
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask
  task automatic take(input int n);
    int k;
    u_lcd_host_model.idle();
    for (k = 0; k < 40 && u_lcd_host_model.got_q.size() < n; k++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic view(input int com, input int sa, input logic ea, input int sb, input logic eb,
                      input logic frame);
    int k;
    u_lcd_host_model.idle();
    if (frame) begin
      for (k = 0; k < FRAME && indicator_common_output[0] === 1'b1; k++) @(negedge sys_clk);
      for (k = 0; k < 2 * FRAME && indicator_common_output[0] !== 1'b1; k++) @(negedge sys_clk);
    end
    for (k = 0; k < FRAME && common_outputs[com][0] !== 1'b1; k++) @(negedge sys_clk);
    chk_bit("segment a", ea, segment_outputs[sa][0]);
    chk_bit("segment b", eb, segment_outputs[sb][0]);
    chk_bit("common polarity", frame_alternation_signal, common_outputs[com][1]);
    @(posedge sys_clk);
  endtask
  task automatic s_power();
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | 8'(i));
      u_lcd_host_model.idle();
      repeat (4) @(posedge sys_clk);
      chk_byte("power", 8'(i), {5'h00, power});
    end
  endtask
  task automatic s_wrap();
    at(4'h0, 8'h82);
    wr(8'hA5);
    wr(8'h3C);
    wr(8'hC3);
    at(4'h0, 8'h82);
    rd();
    rd();
    rd();
    rd();
    take(4);
    chk_byte("column 82", 8'hA5, u_lcd_host_model.got_q[1]);
    chk_byte("column 83", 8'h3C, u_lcd_host_model.got_q[2]);
    chk_byte("page 1 column 0", 8'hC3, u_lcd_host_model.got_q[3]);
  endtask
  task automatic s_last();
    at(4'h8, 8'h83);
    wr(8'hFF);
    wr(8'h5A);
    at(4'h8, 8'h83);
    rd();
    rd();
    rd();
    take(3);
    chk_byte("indicator byte", 8'h01, u_lcd_host_model.got_q[1]);
    chk_byte("page 0 column 0", 8'h5A, u_lcd_host_model.got_q[2]);
  endtask
  task automatic s_fifo();
    int k;
    u_lcd_host_model.got_q.delete();
    stall <= 1'b1;
    rd();
    for (k = 0; k < 20; k++) begin
      u_lcd_host_model.idle();
      @(negedge sys_clk);
      if (wr_ready !== 1'b1) break;
      @(posedge sys_clk);
      cmd(8'hE3);
    end
    chk_bit("refused when full", 1'b0, wr_ready);
    @(posedge sys_clk);
    stall <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk_bit("ready after drain", 1'b1, wr_ready);
    chk_count("answers", 1, u_lcd_host_model.got_q.size());
  endtask
  task automatic s_frame();
    int n;
    logic f;
    f = frame_alternation_signal;
    for (n = 0; n < 2 * FRAME && frame_alternation_signal === f; n++) @(negedge sys_clk);
    f = frame_alternation_signal;
    for (n = 0; n < 2 * FRAME && frame_alternation_signal === f; n++) @(negedge sys_clk);
    chk_count("frame length", FRAME, n);
    @(posedge sys_clk);
  endtask
  task automatic s_ext();
    drive_level_t [63:0] snap;
    display_clock_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    snap = common_outputs;
    repeat (450) @(posedge sys_clk);
    chk_bit("scan held", 1'b1, common_outputs === snap);
    display_clock_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    display_clock_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_bit("scan stepped", 1'b1, common_outputs !== snap);
    display_clock_pin <= 1'b1;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    s_power();
    s_wrap();
    s_last();
    s_fifo();
    at(4'h0, 8'h00);
    wr(8'h03);
    wr(8'h00);
    cmd(8'hAF);
    view(0, 0, 1'b1, 1, 1'b0, 1'b1);
    cmd(8'hA1);
    cmd(8'hA7);
    view(0, 131, 1'b0, 130, 1'b1, 1'b1);
    cmd(8'hA6);
    cmd(8'h41);
    cmd(8'hC8);
    view(63, 131, 1'b1, 130, 1'b0, 1'b1);
    view(62, 131, 1'b0, 130, 1'b0, 1'b0);
    cmd(8'hA5);
    view(63, 131, 1'b1, 130, 1'b1, 1'b1);
    cmd(8'hAE);
    view(63, 131, 1'b0, 130, 1'b0, 1'b1);
    cmd(8'hA4);
    cmd(8'hAF);
    u_lcd_host_model.idle();
    s_frame();
    s_ext();
    cmd(8'hA0);
    cmd(8'hC0);
    cmd(8'h40);
    view(0, 0, 1'b1, 1, 1'b0, 1'b1);
    at(4'h0, 8'h00);
    rd();
    rd();
    take(2);
    chk_byte("memory kept", 8'h03, u_lcd_host_model.got_q[1]);
    print_verdict();
  end
endmodule // lcd_scan_tb
`default_nettype wire
